// >>> hw/scfm_map.vh
`ifndef SCFM_MAP_VH
`define SCFM_MAP_VH
// get/set codes
`define SCFM_CODE_LAST_ERR   8'h20
`define SCFM_CODE_SER2       8'h46
`define SCFM_CODE_GW3        8'h47
`define SCFM_CODE_GW2        8'h48
`define SCFM_CODE_GW1        8'h49
`define SCFM_CODE_GW0        8'h4A
`define SCFM_CODE_GPIB1      8'h4B
`define SCFM_CODE_GPIB2      8'h4C
`define SCFM_CODE_DHCP       8'h4D
`define SCFM_CODE_NETID      8'h4E
`define SCFM_CODE_PSMON      8'h4F
`define SCFM_CODE_FMASK      8'h50
`define SCFM_CODE_POLE       8'h53
// reset values
`define SCFM_RST_GW          8'h00
`define SCFM_RST_DHCP        1'h0
`define SCFM_RST_NETID       8'h00
`define SCFM_RST_PSMON       2'h0
`define SCFM_RST_FMASK       4'h0
// field positions
`define SCFM_FMASK_ALONE     0
`define SCFM_FMASK_SILENT    1
`define SCFM_FMASK_PRESET    2
`define SCFM_FMASK_SECOND    3
`define SCFM_SUMMARY_FAULT   3
`define SCFM_ESR_CME         5
// fault codes
`define SCFM_FC_ALONE_TOP    14'd7900
`define SCFM_FC_ALONE_BOT    14'd8000
`define SCFM_FC_SILENT_TOP   14'd8100
`define SCFM_FC_SILENT_BOT   14'd8200
`define SCFM_FC_PRESET_TOP   14'd8300
`define SCFM_FC_PRESET_BOT   14'd8400
`define SCFM_FC_SECOND_TOP   14'd8500
// discovery
`define SCFM_UDP_PORT        16'd5417
`define SCFM_REPLY_LEN       4'hC
`define SCFM_POLE_IS_POLE    16'hFFFF
`endif

// >>> hw/scfm_fault_logger.v
`timescale 1ns/1ps
`include "scfm_map.vh"
module scfm_fault_logger (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // configuration
  input  wire [3:0]  mask_in,
  input  wire        top_slot_in,
  // incident pulses
  input  wire        alone_in,
  input  wire        silent_in,
  input  wire        partner_reset_in,
  input  wire        top_secondary_in,
  // fault push
  output reg         push_out,
  output reg  [13:0] code_out,
  output reg         primary_out
);
  reg  [3:0] pending;
  wire [3:0] detect;
  wire [3:0] next_pending;
  // gate each incident by its mask bit at detection
  assign detect = {top_secondary_in & top_slot_in & mask_in[`SCFM_FMASK_SECOND],
                   partner_reset_in & mask_in[`SCFM_FMASK_PRESET],
                   silent_in & mask_in[`SCFM_FMASK_SILENT],
                   alone_in & mask_in[`SCFM_FMASK_ALONE]};
  assign next_pending = pending | detect;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending     <= 4'h0;
      push_out    <= 1'b0;
      code_out    <= 14'h0;
      primary_out <= 1'b0;
    end else begin
      push_out <= 1'b0;
      if (partner_reset_in)
        primary_out <= 1'b1;
      else if (top_secondary_in)
        primary_out <= 1'b0;
      if (next_pending[0]) begin
        code_out <= top_slot_in ? `SCFM_FC_ALONE_TOP : `SCFM_FC_ALONE_BOT;
        push_out <= 1'b1;
        pending  <= next_pending & 4'hE;
      end else if (next_pending[1]) begin
        code_out <= top_slot_in ? `SCFM_FC_SILENT_TOP : `SCFM_FC_SILENT_BOT;
        push_out <= 1'b1;
        pending  <= next_pending & 4'hD;
      end else if (next_pending[2]) begin
        code_out <= top_slot_in ? `SCFM_FC_PRESET_TOP : `SCFM_FC_PRESET_BOT;
        push_out <= 1'b1;
        pending  <= next_pending & 4'hB;
      end else if (next_pending[3]) begin
        code_out <= `SCFM_FC_SECOND_TOP;
        push_out <= 1'b1;
        pending  <= next_pending & 4'h7;
      end else begin
        pending <= next_pending;
      end
    end
  end
endmodule

// >>> hw/scfm_discovery.v
`timescale 1ns/1ps
`include "scfm_map.vh"
module scfm_discovery #(
  // arbitrary product code, eight ASCII characters
  parameter [63:0] PRODUCT_CODE = 64'h53574D4630303031
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // datagram arrival
  input  wire       udp_valid_in,
  input  wire       udp_for_us_in,
  input  wire [15:0] udp_port_in,
  input  wire [15:0] udp_len_in,
  input  wire [7:0] net_id_in,
  // reply bytes
  output reg        reply_valid_out,
  output reg  [7:0] reply_byte_out,
  output reg        reply_last_out
);
  reg  [3:0] idx;
  reg        busy;
  reg  [7:0] id;
  function [7:0] scfm_ascii;
    input [7:0] v;
    begin
      scfm_ascii = 8'h30 + v;
    end
  endfunction
  reg  [7:0] sel_byte;
  always @* begin
    sel_byte = 8'h20;
    case (idx)
      4'h8:    sel_byte = 8'h20;
      4'h9:    sel_byte = scfm_ascii(id / 8'd100);
      4'hA:    sel_byte = scfm_ascii((id / 8'd10) % 8'd10);
      4'hB:    sel_byte = scfm_ascii(id % 8'd10);
      default: sel_byte = PRODUCT_CODE[(7 - idx[2:0]) * 8 +: 8];
    endcase
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx             <= 4'h0;
      busy            <= 1'b0;
      id              <= 8'h00;
      reply_valid_out <= 1'b0;
      reply_byte_out  <= 8'h00;
      reply_last_out  <= 1'b0;
    end else begin
      reply_valid_out <= busy;
      reply_byte_out  <= sel_byte;
      reply_last_out  <= busy && (idx == `SCFM_REPLY_LEN - 4'h1);
      if (busy) begin
        idx <= idx + 4'h1;
        if (idx == `SCFM_REPLY_LEN - 4'h1)
          busy <= 1'b0;
      end else if (udp_valid_in && udp_for_us_in &&
                   udp_port_in == `SCFM_UDP_PORT && udp_len_in != 16'h0) begin
        busy <= 1'b1;
        idx  <= 4'h0;
        id   <= net_id_in;
      end
    end
  end
endmodule

// >>> hw/scfm_regbank.v
// What this block does
// - code 70 reads 1 when second CPU serial port fitted, else 0.
// - codes 71..74 hold second CPU gateway octets, MS first.
// - codes 75 and 76 report GPIB fitted on first and second CPU.
// - code 77 DHCP enable, 1 enables, default disabled.
// - code 78 network identifier 0..255, default zero.
// - code 79 two-bit supply monitoring disable selector.
// - code 80 four-bit fault mask, zero keeps old behaviour.
// - weight 1: lone reset logs 7900 top or 8000 bottom.
// - weight 2: lost partner responses log 8100 top or 8200 bottom.
// - weight 4: partner reset logs 8300 or 8400, then primary.
// - weight 8: top CPU reset as secondary logs 8500.
// - last error reads stay while event bit set; else read once, clear.
// - set of selector picks module the next get reports.
// - code 83 get returns owning pole, -1 for pole, 0 invalid pole.
// - UDP on port 5417 answered with product code and identifier.
// - fault summary bit clears once fault queue empties.
// - fault summary bit is status byte weight 8, set while faults queued.
// - code 32 holds most recent error code or zero.
// - event status bits sticky until cleared together.
`timescale 1ns/1ps
`include "scfm_map.vh"
module scfm_regbank #(
  parameter        QUEUE_DEPTH  = 8,
  parameter        QUEUE_AW     = 3,
  parameter        POLE_ENTRIES = 16,
  parameter        POLE_AW      = 4,
  // arbitrary product code, eight ASCII characters
  parameter [63:0] PRODUCT_CODE = 64'h53574D4630303031
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // get/set commands
  input  wire        cmd_valid_in,
  input  wire        cmd_write_in,
  input  wire [7:0]  cmd_code_in,
  input  wire [15:0] cmd_data_in,
  output reg         resp_valid_out,
  output reg  [15:0] resp_data_out,
  output reg         resp_err_out,
  // fitted ports
  input  wire        ser2_fitted_in,
  input  wire        gpib1_fitted_in,
  input  wire        gpib2_fitted_in,
  // pole table load
  input  wire        pole_wr_in,
  input  wire [POLE_AW-1:0] pole_wr_index_in,
  input  wire        pole_wr_is_pole_in,
  input  wire [7:0]  pole_wr_owner_in,
  input  wire        pole_zero_valid_in,
  // error and event status
  input  wire        err_set_in,
  input  wire [15:0] err_code_in,
  input  wire [7:0]  events_in,
  input  wire        esr_clear_in,
  output reg  [7:0]  event_status_latch_out,
  // paired CPU incidents
  input  wire        top_slot_in,
  input  wire        alone_in,
  input  wire        silent_in,
  input  wire        partner_reset_in,
  input  wire        top_secondary_in,
  output reg         primary_out,
  // fault queue
  input  wire        fault_pop_in,
  output reg  [13:0] fault_head_out,
  output reg  [7:0]  status_summary_byte_out,
  // configuration outputs
  output reg  [31:0] gateway_out,
  output reg         dhcp_enable_out,
  output reg  [7:0]  net_id_out,
  output reg         watch_supply1_out,
  output reg         watch_supply2_out,
  output reg  [3:0]  fault_mask_out,
  // discovery
  input  wire        udp_valid_in,
  input  wire        udp_for_us_in,
  input  wire [15:0] udp_port_in,
  input  wire [15:0] udp_len_in,
  output reg         reply_valid_out,
  output reg  [7:0]  reply_byte_out,
  output reg         reply_last_out
);
  // register state
  reg  [7:0]  gw3;
  reg  [7:0]  gw2;
  reg  [7:0]  gw1;
  reg  [7:0]  gw0;
  reg         dhcp;
  reg  [7:0]  net_id;
  reg  [1:0]  psmon;
  reg  [3:0]  fmask;
  reg  [POLE_AW-1:0] pole_sel;
  reg  [15:0] last_err;
  reg  [7:0]  esr;
  // pole table
  reg         pole_is_pole [0:POLE_ENTRIES-1];
  reg  [7:0]  pole_owner   [0:POLE_ENTRIES-1];
  // fault queue
  reg  [13:0] fq_mem [0:QUEUE_DEPTH-1];
  reg  [QUEUE_AW-1:0] fq_wp;
  reg  [QUEUE_AW-1:0] fq_rp;
  reg  [QUEUE_AW:0]   fq_cnt;
  // decoded command
  wire        do_get;
  wire        do_set;
  reg  [15:0] rd_data;
  reg         rd_err;
  // submodule wires
  wire        log_push;
  wire [13:0] log_code;
  wire        log_primary;
  wire        disc_valid;
  wire [7:0]  disc_byte;
  wire        disc_last;
  integer     i;

  assign do_get = cmd_valid_in & ~cmd_write_in;
  assign do_set = cmd_valid_in & cmd_write_in;

  function is_code;
    input [7:0] code;
    input [7:0] want;
    begin
      is_code = (code == want);
    end
  endfunction

  // read multiplexer
  always @* begin
    rd_data = 16'h0000;
    rd_err  = 1'b0;
    case (cmd_code_in)
      `SCFM_CODE_LAST_ERR: rd_data = last_err;
      `SCFM_CODE_SER2:     rd_data = {15'h0, ser2_fitted_in};
      `SCFM_CODE_GW3:      rd_data = {8'h00, gw3};
      `SCFM_CODE_GW2:      rd_data = {8'h00, gw2};
      `SCFM_CODE_GW1:      rd_data = {8'h00, gw1};
      `SCFM_CODE_GW0:      rd_data = {8'h00, gw0};
      `SCFM_CODE_GPIB1:    rd_data = {15'h0, gpib1_fitted_in};
      `SCFM_CODE_GPIB2:    rd_data = {15'h0, gpib2_fitted_in};
      `SCFM_CODE_DHCP:     rd_data = {15'h0, dhcp};
      `SCFM_CODE_NETID:    rd_data = {8'h00, net_id};
      `SCFM_CODE_PSMON:    rd_data = {14'h0, psmon};
      `SCFM_CODE_FMASK:    rd_data = {12'h0, fmask};
      `SCFM_CODE_POLE: begin
        if (pole_sel == {POLE_AW{1'b0}} && !pole_zero_valid_in)
          rd_data = 16'h0000;
        else if (pole_is_pole[pole_sel])
          rd_data = `SCFM_POLE_IS_POLE;
        else
          rd_data = {8'h00, pole_owner[pole_sel]};
      end
      default: rd_err = 1'b1;
    endcase
  end

  // command response
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out  <= 16'h0000;
      resp_err_out   <= 1'b0;
    end else begin
      resp_valid_out <= cmd_valid_in;
      resp_data_out  <= do_get ? rd_data : 16'h0000;
      resp_err_out   <= do_get ? rd_err : 1'b0;
    end
  end

  // writable registers
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gw3      <= `SCFM_RST_GW;
      gw2      <= `SCFM_RST_GW;
      gw1      <= `SCFM_RST_GW;
      gw0      <= `SCFM_RST_GW;
      dhcp     <= `SCFM_RST_DHCP;
      net_id   <= `SCFM_RST_NETID;
      psmon    <= `SCFM_RST_PSMON;
      fmask    <= `SCFM_RST_FMASK;
      pole_sel <= {POLE_AW{1'b0}};
    end else if (do_set) begin
      if (is_code(cmd_code_in, `SCFM_CODE_GW3))
        gw3 <= cmd_data_in[7:0];
      if (is_code(cmd_code_in, `SCFM_CODE_GW2))
        gw2 <= cmd_data_in[7:0];
      if (is_code(cmd_code_in, `SCFM_CODE_GW1))
        gw1 <= cmd_data_in[7:0];
      if (is_code(cmd_code_in, `SCFM_CODE_GW0))
        gw0 <= cmd_data_in[7:0];
      if (is_code(cmd_code_in, `SCFM_CODE_DHCP))
        dhcp <= cmd_data_in[0];
      if (is_code(cmd_code_in, `SCFM_CODE_NETID))
        net_id <= cmd_data_in[7:0];
      if (is_code(cmd_code_in, `SCFM_CODE_PSMON))
        psmon <= cmd_data_in[1:0];
      if (is_code(cmd_code_in, `SCFM_CODE_FMASK))
        fmask <= cmd_data_in[3:0];
      if (is_code(cmd_code_in, `SCFM_CODE_POLE))
        pole_sel <= cmd_data_in[POLE_AW-1:0];
    end
  end

  // pole table, loaded by system firmware
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < POLE_ENTRIES; i = i + 1) begin
        pole_is_pole[i] <= 1'b0;
        pole_owner[i]   <= 8'h00;
      end
    end else if (pole_wr_in) begin
      pole_is_pole[pole_wr_index_in] <= pole_wr_is_pole_in;
      pole_owner[pole_wr_index_in]   <= pole_wr_owner_in;
    end
  end

  // event status latch, set wins over clear
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      esr <= 8'h00;
    end else if (esr_clear_in) begin
      esr <= events_in;
    end else begin
      esr <= esr | events_in;
    end
  end

  // last error: read clears only once its event bit is gone
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_err <= 16'h0000;
    end else if (err_set_in) begin
      last_err <= err_code_in;
    end else if (do_get && is_code(cmd_code_in, `SCFM_CODE_LAST_ERR) &&
                 !esr[`SCFM_ESR_CME]) begin
      last_err <= 16'h0000;
    end
  end

  // queue occupancy, at most one entry in and one out per cycle
  wire [QUEUE_AW:0] fq_inc;
  wire [QUEUE_AW:0] fq_dec;
  wire [QUEUE_AW:0] next_fq_cnt;
  assign fq_inc = {{QUEUE_AW{1'b0}},
                   log_push && fq_cnt != QUEUE_DEPTH[QUEUE_AW:0]};
  assign fq_dec = {{QUEUE_AW{1'b0}},
                   fault_pop_in && fq_cnt != {(QUEUE_AW+1){1'b0}}};
  assign next_fq_cnt = fq_cnt + fq_inc - fq_dec;

  // fault queue, full queue drops new entries
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fq_wp  <= {QUEUE_AW{1'b0}};
      fq_rp  <= {QUEUE_AW{1'b0}};
      fq_cnt <= {(QUEUE_AW+1){1'b0}};
    end else begin
      if (log_push && fq_cnt != QUEUE_DEPTH[QUEUE_AW:0]) begin
        fq_mem[fq_wp] <= log_code;
        fq_wp <= fq_wp + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      end
      if (fault_pop_in && fq_cnt != {(QUEUE_AW+1){1'b0}})
        fq_rp <= fq_rp + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      fq_cnt <= next_fq_cnt;
    end
  end

  // status and configuration outputs
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_summary_byte_out <= 8'h00;
      fault_head_out          <= 14'h0;
      event_status_latch_out  <= 8'h00;
      gateway_out             <= 32'h0;
      dhcp_enable_out         <= 1'b0;
      net_id_out              <= 8'h00;
      watch_supply1_out       <= 1'b0;
      watch_supply2_out       <= 1'b0;
      fault_mask_out          <= 4'h0;
      primary_out             <= 1'b0;
    end else begin
      status_summary_byte_out <= 8'h00;
      status_summary_byte_out[`SCFM_SUMMARY_FAULT] <=
        (next_fq_cnt != {(QUEUE_AW+1){1'b0}});
      fault_head_out         <= fq_mem[fq_rp];
      event_status_latch_out <= esr;
      gateway_out            <= {gw3, gw2, gw1, gw0};
      dhcp_enable_out        <= dhcp;
      net_id_out             <= net_id;
      watch_supply1_out      <= ~psmon[0];
      watch_supply2_out      <= ~psmon[1];
      fault_mask_out         <= fmask;
      primary_out            <= log_primary;
    end
  end

  // discovery reply bytes
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reply_valid_out <= 1'b0;
      reply_byte_out  <= 8'h00;
      reply_last_out  <= 1'b0;
    end else begin
      reply_valid_out <= disc_valid;
      reply_byte_out  <= disc_byte;
      reply_last_out  <= disc_last;
    end
  end

  scfm_fault_logger u_logger (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .mask_in          (fmask),
    .top_slot_in      (top_slot_in),
    .alone_in         (alone_in),
    .silent_in        (silent_in),
    .partner_reset_in (partner_reset_in),
    .top_secondary_in (top_secondary_in),
    .push_out         (log_push),
    .code_out         (log_code),
    .primary_out      (log_primary)
  );

  scfm_discovery #(
    .PRODUCT_CODE (PRODUCT_CODE)
  ) u_discovery (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .udp_valid_in    (udp_valid_in),
    .udp_for_us_in   (udp_for_us_in),
    .udp_port_in     (udp_port_in),
    .udp_len_in      (udp_len_in),
    .net_id_in       (net_id),
    .reply_valid_out (disc_valid),
    .reply_byte_out  (disc_byte),
    .reply_last_out  (disc_last)
  );
endmodule

// >>> verif/scfm_regbank_props.sv
`timescale 1ns/1ps
module scfm_regbank_props (
  // clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // command bus
  input wire        cmd_valid_in,
  input wire        cmd_write_in,
  input wire [7:0]  cmd_code_in,
  input wire [15:0] cmd_data_in,
  // incidents and queue
  input wire        alone_in,
  input wire        silent_in,
  input wire        partner_reset_in,
  input wire        top_secondary_in,
  input wire        fault_pop_in,
  input wire        primary_out,
  input wire [7:0]  status_summary_byte_out,
  // configuration
  input wire        dhcp_enable_out,
  input wire [7:0]  net_id_out,
  input wire        watch_supply1_out,
  input wire        watch_supply2_out,
  input wire [3:0]  fault_mask_out,
  // discovery
  input wire        udp_valid_in,
  input wire        udp_for_us_in,
  input wire [15:0] udp_port_in,
  input wire [15:0] udp_len_in,
  input wire        reply_valid_out,
  input wire        reply_last_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  spare_bits_zero_a: assert property ((status_summary_byte_out & 8'hF7) == 8'h00)
    else $error("status byte spare bits set");
  alone_logged_a: assert property ((alone_in && fault_mask_out[0] && !fault_pop_in)
    |-> ##2 status_summary_byte_out[3]) else $error("lone reset fault not queued");
  silent_logged_a: assert property ((silent_in && fault_mask_out[1] && !fault_pop_in)
    |-> ##[1:2] status_summary_byte_out[3]) else $error("silent partner fault not queued");
  take_primary_a: assert property ((partner_reset_in && fault_mask_out[2]
    && !top_secondary_in) |-> ##[1:2] primary_out) else $error("primary not taken");
  mask_follow_a: assert property ((cmd_valid_in && cmd_write_in && cmd_code_in == 8'h50)
    |-> ##3 fault_mask_out == $past(cmd_data_in[3:0], 3)) else $error("mask output wrong");
  netid_follow_a: assert property ((cmd_valid_in && cmd_write_in && cmd_code_in == 8'h4E)
    |-> ##3 net_id_out == $past(cmd_data_in[7:0], 3)) else $error("net id output wrong");
  dhcp_follow_a: assert property ((cmd_valid_in && cmd_write_in && cmd_code_in == 8'h4D)
    |-> ##3 dhcp_enable_out == $past(cmd_data_in[0], 3)) else $error("dhcp output wrong");
  supply_watch_a: assert property ((cmd_valid_in && cmd_write_in && cmd_code_in == 8'h4F)
    |-> ##3 ({watch_supply2_out, watch_supply1_out} == ~$past(cmd_data_in[1:0], 3)))
    else $error("supply watch decode wrong");
  reply_frame_a: assert property ((udp_valid_in && udp_for_us_in && udp_port_in == 16'h1529
    && udp_len_in != 16'h0000 && !reply_valid_out)
    |-> ##3 (reply_valid_out && !reply_last_out)[*8] ##1 (reply_valid_out && !reply_last_out)[*3]
    ##1 (reply_valid_out && reply_last_out) ##1 !reply_valid_out)
    else $error("discovery reply framing wrong");
endmodule

// >>> verif/scfm_host_model.sv
`timescale 1ns/1ps
module scfm_host_model (
  // clock
  input  wire        clk_in,
  // command bus
  output reg         cmd_valid_out,
  output reg         cmd_write_out,
  output reg  [7:0]  cmd_code_out,
  output reg  [15:0] cmd_data_out,
  input  wire        resp_valid_in,
  input  wire [15:0] resp_data_in,
  input  wire        resp_err_in
);
  integer n;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 16'h0000;
  end
  // one command, taken at one edge; released lines carry inverted values
  task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] q, output e);
    begin
      @(negedge clk_in);
      cmd_valid_out = 1'b1;
      cmd_write_out = w;
      cmd_code_out = c;
      cmd_data_out = d;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      cmd_write_out = ~w;
      cmd_code_out = ~c;
      cmd_data_out = ~d;
      for (n = 0; n < 4 && resp_valid_in !== 1'b1; n = n + 1)
        @(negedge clk_in);
      q = (resp_valid_in === 1'b1) ? resp_data_in : 16'hXXXX;
      e = resp_err_in;
    end
  endtask
endmodule

// >>> verif/scfm_regbank_tb_top.sv
`timescale 1ns/1ps
module scfm_regbank_tb_top;
  // arbitrary product code
  localparam [63:0]  PC = 64'h5445535450523031;
  localparam [31:0]  GW = 32'h11223344;
  localparam [95:0]  RB = {PC, 32'h20323535};
  localparam [111:0] FC = {14'h2134, 14'h206C, 14'h1FA4, 14'h1EDC,
                           14'h0000, 14'h20D0, 14'h2008, 14'h1F40};
  reg         clk_in, rst_in, ser2_fitted_in, gpib1_fitted_in, gpib2_fitted_in;
  reg         pole_wr_in, pole_wr_is_pole_in, pole_zero_valid_in, err_set_in, esr_clear_in;
  reg         top_slot_in, alone_in, silent_in, partner_reset_in, top_secondary_in;
  reg         fault_pop_in, udp_valid_in, udp_for_us_in, e;
  reg  [3:0]  pole_wr_index_in;
  reg  [7:0]  pole_wr_owner_in, events_in;
  reg  [15:0] err_code_in, udp_port_in, udp_len_in, q;
  wire        cmd_valid_in, cmd_write_in, resp_valid_out, resp_err_out, primary_out;
  wire        dhcp_enable_out, watch_supply1_out, watch_supply2_out;
  wire        reply_valid_out, reply_last_out;
  wire [7:0]  cmd_code_in, event_status_latch_out, status_summary_byte_out;
  wire [7:0]  net_id_out, reply_byte_out;
  wire [15:0] cmd_data_in, resp_data_out;
  wire [13:0] fault_head_out;
  wire [31:0] gateway_out;
  wire [3:0]  fault_mask_out;
  integer     err_total, checks, i, s;

  scfm_host_model host_u (.clk_in, .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in),
    .cmd_code_out(cmd_code_in), .cmd_data_out(cmd_data_in), .resp_valid_in(resp_valid_out),
    .resp_data_in(resp_data_out), .resp_err_in(resp_err_out));

  scfm_regbank #(.PRODUCT_CODE(PC)) dut_u (.clk_in, .rst_in, .cmd_valid_in, .cmd_write_in,
    .cmd_code_in, .cmd_data_in, .resp_valid_out, .resp_data_out, .resp_err_out,
    .ser2_fitted_in, .gpib1_fitted_in, .gpib2_fitted_in, .pole_wr_in, .pole_wr_index_in,
    .pole_wr_is_pole_in, .pole_wr_owner_in, .pole_zero_valid_in, .err_set_in, .err_code_in,
    .events_in, .esr_clear_in, .event_status_latch_out, .top_slot_in, .alone_in, .silent_in,
    .partner_reset_in, .top_secondary_in, .primary_out, .fault_pop_in, .fault_head_out,
    .status_summary_byte_out, .gateway_out, .dhcp_enable_out, .net_id_out,
    .watch_supply1_out, .watch_supply2_out, .fault_mask_out, .udp_valid_in, .udp_for_us_in,
    .udp_port_in, .udp_len_in, .reply_valid_out, .reply_byte_out, .reply_last_out);

  always #5 clk_in = ~clk_in;

  task check(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  task get(input [7:0] c, input [15:0] want);
    begin
      host_u.xfer(1'b0, c, 16'h0000, q, e);
      check({16'h0000, q}, {16'h0000, want});
    end
  endtask
  task set(input [7:0] c, input [15:0] d);
    host_u.xfer(1'b1, c, d, q, e);
  endtask
  task end_sim;
    begin
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim;
  end

  initial begin
    err_total = 0;
    checks = 0;
    {clk_in, ser2_fitted_in, gpib1_fitted_in, gpib2_fitted_in, pole_wr_in, pole_wr_is_pole_in,
     pole_zero_valid_in, err_set_in, esr_clear_in, top_slot_in, alone_in, silent_in,
     partner_reset_in, top_secondary_in, fault_pop_in, udp_valid_in, udp_for_us_in,
     pole_wr_index_in, pole_wr_owner_in, events_in, err_code_in, udp_port_in, udp_len_in} = 0;
    rst_in = 1'b1;
    cyc(20);
    rst_in = 1'b0;
    cyc(2);
    get(8'h4D, 16'h0000);
    get(8'h4E, 16'h0000);
    get(8'h50, 16'h0000);
    host_u.xfer(1'b0, 8'h60, 16'h0000, q, e);
    check({16'h0000, q}, 32'h0);
    check({31'h0, e}, 32'h1);
    for (i = 0; i < 2; i = i + 1) begin
      {ser2_fitted_in, gpib1_fitted_in, gpib2_fitted_in} = i ? 3'h2 : 3'h5;
      get(8'h46, {15'h0, ser2_fitted_in});
      get(8'h4B, {15'h0, gpib1_fitted_in});
      get(8'h4C, {15'h0, gpib2_fitted_in});
    end
    for (i = 0; i < 4; i = i + 1)
      set(8'h47 + i[7:0], {8'h00, GW[31-8*i -: 8]});
    for (i = 0; i < 4; i = i + 1)
      get(8'h47 + i[7:0], {8'h00, GW[31-8*i -: 8]});
    check(gateway_out, GW);
    set(8'h4D, 16'h0001);
    cyc(1);
    set(8'h4E, 16'h00FF);
    get(8'h4D, 16'h0001);
    get(8'h4E, 16'h00FF);
    for (i = 0; i < 4; i = i + 1) begin
      set(8'h4F, {14'h0, i[1:0]});
      get(8'h4F, {14'h0, i[1:0]});
      cyc(2);
      check({watch_supply2_out, watch_supply1_out}, {30'h0, ~i[1:0]});
    end
    // every incident kind from the top slot, all but the secondary reset from the bottom, mask fully open
    set(8'h50, 16'h000F);
    get(8'h50, 16'h000F);
    cyc(3);
    for (s = 0; s < 2; s = s + 1) begin
      top_slot_in = s[0];
      for (i = 0; i < 4; i = i + 1) if (s == 1 || i < 3) begin
        {top_secondary_in, partner_reset_in, silent_in, alone_in} = 4'h1 << i;
        cyc(1);
        {top_secondary_in, partner_reset_in, silent_in, alone_in} = 4'h0;
        cyc(3);
        check(status_summary_byte_out, 32'h8);
        check(fault_head_out, FC[(s*4+i)*14 +: 14]);
        if (i > 1) check(primary_out, {31'h0, i == 2});
        fault_pop_in = 1'b1;
        cyc(1);
        fault_pop_in = 1'b0;
        cyc(2);
        check(status_summary_byte_out, 32'h0);
      end
    end
    set(8'h50, 16'h0000);
    cyc(3);
    alone_in = 1'b1;
    cyc(1);
    alone_in = 1'b0;
    cyc(3);
    check(status_summary_byte_out, 32'h0);
    // last error kept while the event bit stands, then read once
    events_in = 8'h20;
    err_code_in = 16'h0042;
    err_set_in = 1'b1;
    cyc(1);
    events_in = 8'h00;
    err_set_in = 1'b0;
    cyc(2);
    check(event_status_latch_out, 32'h20);
    get(8'h20, 16'h0042);
    get(8'h20, 16'h0042);
    esr_clear_in = 1'b1;
    cyc(1);
    esr_clear_in = 1'b0;
    cyc(2);
    check(event_status_latch_out, 32'h0);
    get(8'h20, 16'h0042);
    get(8'h20, 16'h0000);
    pole_zero_valid_in = 1'b1;
    pole_wr_owner_in = 8'h05;
    pole_wr_in = 1'b1;
    cyc(1);
    pole_wr_index_in = 4'h1;
    pole_wr_is_pole_in = 1'b1;
    cyc(1);
    pole_wr_in = 1'b0;
    set(8'h53, 16'h0000);
    get(8'h53, 16'h0005);
    set(8'h53, 16'h0001);
    get(8'h53, 16'hFFFF);
    pole_zero_valid_in = 1'b0;
    set(8'h53, 16'h0000);
    get(8'h53, 16'h0000);
    // discovery reply, a trigger mid-reply, then a foreign port
    {udp_port_in, udp_len_in, udp_for_us_in, udp_valid_in} = {16'h1529, 16'h0001, 2'h3};
    cyc(1);
    udp_valid_in = 1'b0;
    for (i = 0; i < 8 && reply_valid_out !== 1'b1; i = i + 1)
      cyc(1);
    for (i = 0; i < 12; i = i + 1) begin
      udp_valid_in = (i == 5);
      check({reply_valid_out, reply_last_out}, {30'h0, 1'b1, i == 11});
      check(reply_byte_out, {24'h0, RB[95-8*i -: 8]});
      cyc(1);
    end
    udp_valid_in = 1'b0;
    cyc(4);
    check(reply_valid_out, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      {udp_port_in, udp_len_in} = i ? {16'h1529, 16'h0000} : {16'h152A, 16'h0001};
      udp_valid_in = 1'b1;
      cyc(1);
      udp_valid_in = 1'b0;
      cyc(4);
      check(reply_valid_out, 32'h0);
    end
    end_sim;
  end
endmodule

bind scfm_regbank scfm_regbank_props props_u (.clk_in, .rst_in, .cmd_valid_in, .cmd_write_in,
  .cmd_code_in, .cmd_data_in, .alone_in, .silent_in, .partner_reset_in, .top_secondary_in,
  .fault_pop_in, .primary_out, .status_summary_byte_out, .dhcp_enable_out, .net_id_out,
  .watch_supply1_out, .watch_supply2_out, .fault_mask_out, .udp_valid_in, .udp_for_us_in,
  .udp_port_in, .udp_len_in, .reply_valid_out, .reply_last_out);
